// ---- logic/bcc_regs.svh ----
// bcc_regs.svh - offsets, field positions, reset values of the command block
// assumes: included by bare name from the top module, the checker and the bench
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// register byte offsets
`define BCC_CMD_OFF        12'h000
`define BCC_EVT_OFF        12'h004
`define BCC_MASK_OFF       12'h008

// command field positions
`define BCC_IO_SPACE_BIT   0
`define BCC_MEM_SPACE_BIT  1
`define BCC_BUS_MASTER_BIT 2
`define BCC_WR_INV_BIT     4
`define BCC_PARITY_BIT     6
`define BCC_PCI_SYSTEM_ERROR_PIN_BIT       8

// writable command bits and reset values
`define BCC_CMD_WR_MASK    16'h0157
`define BCC_CMD_RESET      16'h0000
`define BCC_EVT_RESET      4'h0
`define BCC_MASK_RESET     4'h0

// event status bit positions
`define BCC_EVT_MDP        0
`define BCC_EVT_SSERR      1
`define BCC_EVT_MEM_UR     2
`define BCC_EVT_IO_UR      3

// bus answers
`define BCC_RESP_OKAY      2'h0
`define BCC_RESP_SLVERR    2'h2

`endif

// ---- logic/bcc_pkg.sv ----
// bcc_pkg.sv - types shared by the command block and its users
// assumes: bcc_regs.svh sits on the include path
`default_nettype none

package bcc_pkg;

    // command register, bit 15 down to bit 0
    typedef struct packed {
        logic [4:0] unused_high;
        logic       interrupt_disable_zero;
        logic       fast_b2b_enable_zero;
        logic       system_error_report_enable;
        logic       stepping_zero;
        logic       parity_error_response_enable;
        logic       palette_snoop_zero;
        logic       write_invalidate_promote_enable;
        logic       special_cycle_zero;
        logic       bus_master_enable;
        logic       memory_space_enable;
        logic       io_space_enable;
    } bcc_cmd_s;

    // request seen on the pcie side, one-cycle strobes
    typedef struct packed {
        logic mem_req;
        logic mem_is_write;
        logic io_req;
    } bcc_tgt_req_s;

    // decision for that request, one-cycle strobes
    typedef struct packed {
        logic mem_fwd;
        logic mem_promote;
        logic mem_ur;
        logic io_fwd;
        logic io_ur;
    } bcc_tgt_dec_s;

    typedef struct packed {
        logic nonfatal;
        logic fatal;
    } bcc_err_s;

    typedef logic [3:0] bcc_evt_t;

endpackage

`default_nettype wire

// ---- logic/bcc_top.sv ----
// bcc_top.sv - command-control register bank of the pcie-to-pci bridge
// assumes: axi4-lite master on one clock, datapath strobes synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
`include "bcc_regs.svh"

module bcc_top
    import bcc_pkg::*;
#(
    parameter int ADDR_W        = 12,
    parameter bit PCI_SYSTEM_ERROR_PIN_AS_FATAL = 1'b0
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire bcc_tgt_req_s      tgt_req,
    output bcc_tgt_dec_s           tgt_dec,
    input  wire logic              pci_mem_req,
    output logic                   pci_mem_fwd,
    input  wire logic              upstream_req,
    output logic                   upstream_grant,
    input  wire logic              poisoned_tlp,
    input  wire bcc_err_s          bridge_err,
    input  wire logic              dev_ctl_nonfatal_en,
    input  wire logic              dev_ctl_fatal_en,
    input  wire logic              pci_system_error_pin_n,
    output bcc_err_s               err_msg,
    output logic                   master_data_parity_error,
    output logic                   signaled_system_error,
    output bcc_cmd_s               cmd,
    output logic                   irq
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
        $error("bcc_top: ADDR_W must lie in 4..32");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]       cmd_r;
    bcc_evt_t          evt_r;
    bcc_evt_t          evt_nxt;
    bcc_evt_t          mask_r;
    bcc_evt_t          evt_set;
    logic              aw_have_r;
    logic              w_have_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic [31:0]       wmask;
    logic              wr_go;
    logic              rd_go;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              pci_system_error_pin_pin_prev_r;
    logic              pci_system_error_pin_assert;
    logic              nonfatal_en;
    logic              fatal_en;
    logic              msg_nonfatal;
    logic              msg_fatal;
    logic              msg_any;
    logic              mdp_hit;
    bcc_tgt_dec_s      dec_r;
    logic              pci_mem_fwd_r;
    bcc_err_s          err_msg_r;
    logic              mdp_r;
    logic              sserr_r;

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    // address and data are held independently so either may come first
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign wr_go         = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end
    end

    for (genvar gi = 0; gi < 4; gi++) begin : g_lane
        assign wmask[8*gi +: 8] = {8{wstrb_r[gi]}};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `BCC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            case (awaddr_r)
                `BCC_CMD_OFF,
                `BCC_EVT_OFF,
                `BCC_MASK_OFF: bresp_r <= `BCC_RESP_OKAY;
                default:       bresp_r <= `BCC_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ------------------------------------------------------------
    // command and mask registers
    // ------------------------------------------------------------
    // only the six control bits can ever hold a one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= `BCC_CMD_RESET;
        end else if (wr_go && awaddr_r == `BCC_CMD_OFF) begin
            cmd_r <= (cmd_r & ~(wmask[15:0] & `BCC_CMD_WR_MASK))
                   | (wdata_r[15:0] & wmask[15:0] & `BCC_CMD_WR_MASK);
        end
    end
    assign cmd = bcc_cmd_s'(cmd_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= `BCC_MASK_RESET;
        end else if (wr_go && awaddr_r == `BCC_MASK_OFF) begin
            mask_r <= (mask_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `BCC_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `BCC_RESP_OKAY;
            case (s_axi_araddr)
                `BCC_CMD_OFF:  rdata_r <= {16'h0000, cmd_r};
                `BCC_EVT_OFF:  rdata_r <= {28'h0000000, evt_r};
                `BCC_MASK_OFF: rdata_r <= {28'h0000000, mask_r};
                default: begin
                    rdata_r <= '0;
                    rresp_r <= `BCC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ------------------------------------------------------------
    // target decode of pcie requests
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec_r <= '0;
        end else begin
            dec_r.mem_fwd     <= tgt_req.mem_req && cmd.memory_space_enable;
            dec_r.mem_ur      <= tgt_req.mem_req && !cmd.memory_space_enable;
            dec_r.mem_promote <= tgt_req.mem_req && tgt_req.mem_is_write
                              && cmd.memory_space_enable
                              && cmd.write_invalidate_promote_enable;
            dec_r.io_fwd      <= tgt_req.io_req && cmd.io_space_enable;
            dec_r.io_ur       <= tgt_req.io_req && !cmd.io_space_enable;
        end
    end
    assign tgt_dec = dec_r;

    // upstream memory traffic from pci is never blocked by memory space
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pci_mem_fwd_r <= 1'b0;
        end else begin
            pci_mem_fwd_r <= pci_mem_req;
        end
    end

    assign pci_mem_fwd = pci_mem_fwd_r;

    // grant is combinational so the master sees it in the request cycle
    assign upstream_grant = upstream_req && cmd.bus_master_enable;

    // ------------------------------------------------------------
    // error reporting
    // ------------------------------------------------------------
    // the pin is active low; only its falling edge counts as one assertion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pci_system_error_pin_pin_prev_r <= 1'b1;
        end else begin
            pci_system_error_pin_pin_prev_r <= pci_system_error_pin_n;
        end
    end

    assign pci_system_error_pin_assert = pci_system_error_pin_pin_prev_r && !pci_system_error_pin_n
                      && cmd.system_error_report_enable;

    assign nonfatal_en = cmd.system_error_report_enable || dev_ctl_nonfatal_en;
    assign fatal_en    = cmd.system_error_report_enable || dev_ctl_fatal_en;

    assign msg_nonfatal = (bridge_err.nonfatal && nonfatal_en)
                       || (pci_system_error_pin_assert && !PCI_SYSTEM_ERROR_PIN_AS_FATAL);
    assign msg_fatal    = (bridge_err.fatal && fatal_en)
                       || (pci_system_error_pin_assert && PCI_SYSTEM_ERROR_PIN_AS_FATAL);
    assign msg_any      = msg_nonfatal || msg_fatal;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_msg_r <= '0;
        end else begin
            err_msg_r.nonfatal <= msg_nonfatal;
            err_msg_r.fatal    <= msg_fatal;
        end
    end

    assign err_msg = err_msg_r;

    // ------------------------------------------------------------
    // status set strobes toward the outside status register
    // ------------------------------------------------------------
    assign mdp_hit = poisoned_tlp && cmd.parity_error_response_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mdp_r   <= 1'b0;
            sserr_r <= 1'b0;
        end else begin
            mdp_r   <= mdp_hit;
            sserr_r <= msg_any && cmd.system_error_report_enable;
        end
    end

    assign master_data_parity_error = mdp_r;
    assign signaled_system_error    = sserr_r;

    // ------------------------------------------------------------
    // sticky events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        evt_set                 = '0;
        evt_set[`BCC_EVT_MDP]    = mdp_hit;
        evt_set[`BCC_EVT_SSERR]  = msg_any && cmd.system_error_report_enable;
        evt_set[`BCC_EVT_MEM_UR] = tgt_req.mem_req && !cmd.memory_space_enable;
        evt_set[`BCC_EVT_IO_UR]  = tgt_req.io_req && !cmd.io_space_enable;
    end

    // a read clears the word it returned, but a set in that cycle survives
    always_comb begin
        evt_nxt = evt_r;
        if (rd_go && s_axi_araddr == `BCC_EVT_OFF) begin
            evt_nxt = '0;
        end
        evt_nxt = evt_nxt | evt_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_r <= `BCC_EVT_RESET;
        end else begin
            evt_r <= evt_nxt;
        end
    end

    assign irq = |(evt_r & mask_r);

endmodule

`default_nettype wire

// ---- dv/bcc_chk_props.sv ----
// bcc_chk_props.sv - port assertions for the command block
// assumes: bound onto bcc_top, one clock, aresetn synchronous active low
`timescale 1ns/1ps
`default_nettype none
`include "bcc_regs.svh"

module bcc_chk
    import bcc_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire bcc_tgt_req_s tgt_req,
    input wire bcc_tgt_dec_s tgt_dec,
    input wire logic         upstream_req,
    input wire logic         upstream_grant,
    input wire logic         poisoned_tlp,
    input wire bcc_err_s     bridge_err,
    input wire logic         dev_ctl_fatal_en,
    input wire logic         pci_system_error_pin_n,
    input wire bcc_err_s     err_msg,
    input wire logic         master_data_parity_error,
    input wire logic         signaled_system_error,
    input wire bcc_cmd_s     cmd
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_mem_gate: assert property (tgt_req.mem_req |=>
        tgt_dec.mem_fwd == $past(cmd.memory_space_enable) && tgt_dec.mem_ur != tgt_dec.mem_fwd)
        else $error("memory decision wrong");
    chk_io_gate: assert property (tgt_req.io_req |=>
        tgt_dec.io_fwd == $past(cmd.io_space_enable) && tgt_dec.io_ur != tgt_dec.io_fwd)
        else $error("io decision wrong");
    chk_promote_gate: assert property (tgt_req.mem_req |=> tgt_dec.mem_promote ==
        $past(tgt_req.mem_is_write && cmd.memory_space_enable
        && cmd.write_invalidate_promote_enable)) else $error("promote decision wrong");
    chk_grant_gate: assert property (
        upstream_grant == (upstream_req && cmd.bus_master_enable)) else $error("grant wrong");
    // inputs seen during reset must not count
    chk_parity_gate: assert property ($past(aresetn) |-> master_data_parity_error ==
        $past(poisoned_tlp && cmd.parity_error_response_enable)) else $error("parity wrong");
    chk_fatal_msg: assert property (bridge_err.fatal |=> err_msg.fatal ==
        $past(cmd.system_error_report_enable || dev_ctl_fatal_en)) else $error("fatal wrong");
    chk_pin_msg: assert property ($past(aresetn) && $fell(pci_system_error_pin_n)
        && !bridge_err.nonfatal |=> err_msg.nonfatal == $past(cmd.system_error_report_enable))
        else $error("pin message wrong");
    chk_sserr_set: assert property (signaled_system_error ==
        ((err_msg.nonfatal || err_msg.fatal) && $past(cmd.system_error_report_enable)))
        else $error("signaled error wrong");
    chk_zero_fields: assert property ((cmd & ~`BCC_CMD_WR_MASK) == 16'h0000)
        else $error("read-only field set");
endmodule

bind bcc_top bcc_chk u_bcc_chk (.aclk, .aresetn, .tgt_req, .tgt_dec, .upstream_req,
    .upstream_grant, .poisoned_tlp, .bridge_err, .dev_ctl_fatal_en, .pci_system_error_pin_n,
    .err_msg, .master_data_parity_error, .signaled_system_error, .cmd);

`default_nettype wire

// ---- dv/bcc_rc_model.sv ----
// bcc_rc_model.sv - root complex end: tallies error messages sent upstream
// assumes: message strobes are single-cycle pulses on aclk
`timescale 1ns/1ps
`default_nettype none

module bcc_rc_model
    import bcc_pkg::*;
(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire bcc_err_s err_msg,
    output logic [7:0]    nonfatal_cnt_r,
    output logic [7:0]    fatal_cnt_r
);
    // one pulse is one message, so a stuck strobe shows as excess count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nonfatal_cnt_r <= 8'h00;
            fatal_cnt_r <= 8'h00;
        end else begin
            nonfatal_cnt_r <= nonfatal_cnt_r + 8'(err_msg.nonfatal);
            fatal_cnt_r <= fatal_cnt_r + 8'(err_msg.fatal);
        end
    end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top.sv - random and corner-case bench for the command block
// assumes: design, root complex model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "bcc_regs.svh"

module tb_top
    import bcc_pkg::*;
;
    logic         aclk = 1'b0, aresetn = 1'b0, irq;
    logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = 4'hF;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic         s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_bvalid, s_axi_rvalid;
    logic         s_axi_awready, s_axi_wready, s_axi_arready, pci_mem_fwd, upstream_grant;
    logic         pci_mem_req = 1'b0, upstream_req = 1'b0, poisoned_tlp = 1'b0;
    logic         dev_ctl_nonfatal_en = 1'b0, dev_ctl_fatal_en = 1'b0;
    logic         pci_system_error_pin_n = 1'b1, master_data_parity_error, signaled_system_error;
    bcc_tgt_req_s tgt_req = '0;
    bcc_tgt_dec_s tgt_dec;
    bcc_err_s     bridge_err = '0, err_msg;
    bcc_cmd_s     cmd;
    logic [7:0]   nf_seen, f_seen;
    int           failures = 0, total_checks = 0;
    bcc_top u_bcc_top (.*);
    bcc_rc_model u_bcc_rc_model (.aclk(aclk), .aresetn(aresetn), .err_msg(err_msg),
        .nonfatal_cnt_r(nf_seen), .fatal_cnt_r(f_seen));
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // ready is sampled mid-cycle, where it equals its value at the next edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 50 && !tb; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        chk("write answer", 1'b1, tb);
        if (!tb) stop_test();
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ta, tv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        tv = 1'b0;
        for (int n = 0; n < 50 && !tv; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        chk("read answer", 1'b1, tv);
        if (!tv) stop_test();
    endtask
    function automatic bcc_tgt_dec_s exp_dec(bcc_cmd_s c, bcc_tgt_req_s q);
        logic f;
        f = q.mem_req & c.memory_space_enable;
        return {f, f & q.mem_is_write & c.write_invalidate_promote_enable,
                q.mem_req & !f, q.io_req & c.io_space_enable, q.io_req & !c.io_space_enable};
    endfunction
    initial begin
        bcc_cmd_s     ec;
        bcc_tgt_dec_s ed;
        bcc_err_s     ee;
        logic [31:0]  d, q;
        logic [1:0]   r;
        logic [3:0]   m, ev;
        int           nf, fa;
        nf = 0;
        fa = 0;
        void'($urandom(32'hFC12));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 3; k++) begin
            axi_rd(12'(4 * k), d, r);
            chk("reset value", 32'h0, d);
        end
        axi_wr(`BCC_CMD_OFF, 32'hFFFF_FFFF, r);
        axi_rd(`BCC_CMD_OFF, d, r);
        chk("writable bits", {16'h0, `BCC_CMD_WR_MASK}, d);
        axi_wr(12'h00C, 32'h1, r);
        chk("unmapped write", `BCC_RESP_SLVERR, r);
        $display("test registers done");
        // first two passes: every enable off, then every bit written high
        for (int i = 0; i < 40; i++) begin
            d = (i < 2) ? {32{i[0]}} : $urandom;
            ec = d[15:0] & `BCC_CMD_WR_MASK;
            m = d[19:16];
            axi_wr(`BCC_CMD_OFF, d, r);
            axi_wr(`BCC_MASK_OFF, {28'h0, m}, r);
            chk("command", ec, cmd);
            q = $urandom;
            tgt_req <= q[2:0];
            pci_mem_req <= q[3];
            poisoned_tlp <= q[4];
            upstream_req <= q[5];
            @(negedge aclk);
            chk("grant", q[5] & ec.bus_master_enable, upstream_grant);
            @(posedge aclk);
            tgt_req <= '0;
            pci_mem_req <= 1'b0;
            poisoned_tlp <= 1'b0;
            @(negedge aclk);
            ed = exp_dec(ec, q[2:0]);
            ev = {ed.io_ur, ed.mem_ur, 1'b0, q[4] & ec.parity_error_response_enable};
            chk("decision", ed, tgt_dec);
            chk("pci forward", q[3], pci_mem_fwd);
            chk("parity", ev[0], master_data_parity_error);
            chk("irq", |(ev & m), irq);
            @(posedge aclk);
            axi_rd(`BCC_EVT_OFF, d, r);
            chk("event", ev, d);
        end
        $display("test target gating done");
        ev = 4'h0;
        for (int i = 0; i < 32; i++) begin
            axi_wr(`BCC_CMD_OFF, {23'h0, i[0], 8'h0}, r);
            dev_ctl_nonfatal_en <= i[1];
            dev_ctl_fatal_en <= i[2];
            bridge_err <= {i[3], i[4]};
            pci_system_error_pin_n <= i[3];
            ee.nonfatal = (i[3] & (i[0] | i[1])) | (!i[3] & i[0]);
            ee.fatal = i[4] & (i[0] | i[2]);
            nf += ee.nonfatal;
            fa += ee.fatal;
            ev[1] = ev[1] | (i[0] & |ee);
            @(posedge aclk);
            bridge_err <= '0;
            pci_system_error_pin_n <= 1'b1;
            @(negedge aclk);
            chk("error message", ee, err_msg);
            chk("signaled error", i[0] & |ee, signaled_system_error);
            @(posedge aclk);
        end
        // the tally of the last message lands on the edge just passed
        @(negedge aclk);
        chk("nonfatal count", nf, nf_seen);
        chk("fatal count", fa, f_seen);
        chk("error irq", |(ev & m), irq);
        @(posedge aclk);
        axi_rd(`BCC_EVT_OFF, d, r);
        chk("error event", ev, d);
        $display("test error reporting done");
        axi_wr(`BCC_CMD_OFF, 32'hFFFF_FFFF, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        chk("command after reset", 32'h0, cmd);
        chk("irq after reset", 1'b0, irq);
        @(posedge aclk);
        axi_rd(`BCC_MASK_OFF, d, r);
        chk("mask after reset", 32'h0, d);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule

`default_nettype wire
